// ===== core/meter_pkg.sv
package meter_pkg;
  localparam int CLK_HZ = 40_000_000;
  localparam int LAMP_TIME_MS = 3000;
  localparam int FLASH_TIME_MS = 500;
  localparam int DEBOUNCE_TIME_US = 20000;
  localparam int LAMP_CYCLES = LAMP_TIME_MS * (CLK_HZ / 1000);
  localparam int FLASH_CYCLES = FLASH_TIME_MS * (CLK_HZ / 1000);
  localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_US * (CLK_HZ / 1000000);

  // settings and readings in display counts
  localparam logic signed [15:0] SET_MIN = 16'hF831;
  localparam logic signed [15:0] SET_MAX = 16'h270F;
  localparam logic signed [15:0] OFFSET_RST = 16'h0000;
  localparam logic signed [15:0] SCALE_RST = 16'h07D0;
  localparam logic signed [15:0] SPAN_RST = 16'h270F;
  // converter result in millivolts
  localparam logic signed [15:0] IN_MIN_MV = 16'hFC18;
  localparam logic signed [15:0] IN_MAX_MV = 16'h07D0;
  localparam logic signed [31:0] REF_MV = 32'sh000007D0;
  // output trims in hundredths of mA or V, then radix point limits
  localparam logic signed [15:0] CUR_LO_MIN = 16'hFFE2;
  localparam logic signed [15:0] CUR_LO_MAX = 16'h06A4;
  localparam logic signed [15:0] CUR_HI_MIN = 16'h06A4;
  localparam logic signed [15:0] CUR_HI_MAX = 16'h0834;
  localparam logic signed [15:0] VLT_LO_MIN = 16'hFFC4;
  localparam logic signed [15:0] VLT_LO_MAX = 16'h0320;
  localparam logic signed [15:0] VLT_HI_MIN = 16'h0320;
  localparam logic signed [15:0] VLT_HI_MAX = 16'h0406;
  localparam logic signed [15:0] TRIM_LO_RST = 16'h0000;
  localparam logic signed [15:0] TRIM_HI_RST = 16'h03E8;
  localparam logic signed [15:0] RADIX_MIN = 16'h0000;
  localparam logic signed [15:0] RADIX_MAX = 16'h0003;
  localparam logic [1:0] RADIX_RST = 2'h0;

  // bus word indices and fields
  localparam logic [2:0] REG_CTRL = 3'h0;
  localparam logic [2:0] REG_STATUS = 3'h1;
  localparam logic [2:0] REG_OFFSET = 3'h2;
  localparam logic [2:0] REG_SCALE = 3'h3;
  localparam logic [2:0] REG_TRIM = 3'h4;
  localparam logic [2:0] REG_READING = 3'h5;
  localparam logic [2:0] REG_SPAN = 3'h6;
  localparam int CTRL_VOLT_BIT = 0;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_OVER_LSB = 4;
  localparam int ST_AOUT_BIT = 6;
  localparam int TRIM_HI_LSB = 16;

  typedef enum logic [3:0] {
    ST_LAMP = 4'h0, ST_RUN = 4'h1, ST_CAL_OFF = 4'h3, ST_CAL_ON = 4'h2,
    ST_SEL = 4'h6, ST_ZERO_SHIFT_PARAMETER = 4'h7, ST_GAIN_PARAMETER = 4'h5, ST_RADIX = 4'h4,
    ST_OLOW = 4'hC, ST_OHIGH = 4'hD, ST_SPAN = 4'hF
  } menu_state_type;

  typedef enum logic [2:0] {
    DK_LAMP = 3'h0, DK_NUM = 3'h1, DK_LABEL = 3'h2, DK_OVER_TOP = 3'h3,
    DK_OVER_BOT = 3'h4, DK_BLANK = 3'h5
  } disp_kind_type;

  typedef enum logic [3:0] {
    LB_NONE = 4'h0, LB_CAL = 4'h1, LB_OFF = 4'h2, LB_ON = 4'h3,
    LB_OUT = 4'h4, LB_INPUT = 4'h5, LB_ZERO_SHIFT = 4'h6, LB_GAIN = 4'h7,
    LB_RADIX = 4'h8, LB_LOW_TRIM = 4'h9, LB_HIGH_TRIM = 4'hA, LB_SPAN = 4'hB
  } label_type;

  localparam logic [1:0] OVER_NONE = 2'h0;
  localparam logic [1:0] OVER_POS = 2'h1;
  localparam logic [1:0] OVER_NEG = 2'h2;

  typedef struct packed {
    disp_kind_type kind;
    label_type label;
    logic signed [15:0] value;
    logic [1:0] radix;
  } disp_type;

  typedef struct packed {
    logic prog;
    logic up;
    logic down;
    logic prog_up;
    logic prog_down;
  } btn_evt_type;
endpackage

// ===== core/meter_menu.sv
// Functional notes
// R1 - after reset light all digits three seconds, then show the measurement
// R2 - offset spans -1999 to +9999, resets to 0
// R3 - offset is the reading for zero input, the intercept term
// R4 - scale factor spans -1999 to +9999, resets to 2000
// R5 - reading equals scale factor at 2 V input, plus offset
// R6 - input outside -1 V to +2 V is overrange, no reading shown
// R7 - single button acts on its release, one menu step
// R8 - paired buttons act only when held together, on release
// R9 - while editing, display alternates code name and value
// R10 - up release increments, down release decrements the edited value
// R11 - steps of absent optional hardware are skipped
// R12 - calibration shows cal/off, arrows give on, program offers in/out
// R13 - without analog output skip in/out choice, go straight to offset
// R14 - input path: offset with old value, then scale with old value
// R15 - after scale accepted, go to radix point choice with old value
// R16 - edited value stored only on program press
// R17 - low trim limits -0.3..17 mA or -0.6..8 V
// R18 - high trim limits 17..21 mA or 8..10.3 V, program exits to run
// R19 - after low trim accepted, present high trim with its value
// R20 - output branch without output hardware shows span instead
// R21 - positive overrange flashes top segments, negative flashes bottom
// R22 - program with an arrow enters calibration
// R23 - buttons debounced, one event per press and release
// R24 - settings persist across menu exits and reload as previous values
`timescale 1ns/1ps
`default_nettype none
module meter_menu
  import meter_pkg::*;
#(
  parameter int LAMP_CYC = LAMP_CYCLES,
  parameter int FLASH_CYC = FLASH_CYCLES,
  parameter int DEB_CYC = DEBOUNCE_CYCLES
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_btn_program,
  input wire logic i_btn_up,
  input wire logic i_btn_down,
  input wire logic i_aout_present,
  input wire logic i_conv_valid,
  input wire logic signed [15:0] i_conv_mv,
  input wire logic [2:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output disp_type o_disp,
  output logic signed [15:0] o_trim_low,
  output logic signed [15:0] o_trim_high,
  output logic signed [15:0] o_span,
  output logic o_aout_volt_mode
);
  localparam int DEB_W = $clog2(DEB_CYC) + 1;
  localparam int LAMP_W = $clog2(LAMP_CYC) + 1;
  localparam int FLASH_W = $clog2(FLASH_CYC) + 1;

  // pin synchronisers: prog, up, down, output-present
  logic [3:0] sync1_q, sync2_q;
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1_q <= 4'h0;
      sync2_q <= 4'h0;
    end else begin
      sync1_q <= {i_aout_present, i_btn_down, i_btn_up, i_btn_program};
      sync2_q <= sync1_q;
    end
  end
  logic aout_ok;
  assign aout_ok = sync2_q[3];

  // debounce: a level must hold steady for the full window to count
  logic [2:0] held;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : gen_deb
      logic [DEB_W-1:0] cnt_q, cnt_d;
      logic stable_q, stable_d;
      always_comb begin
        cnt_d = '0;
        stable_d = stable_q;
        if (sync2_q[g] != stable_q) begin
          if (cnt_q == DEB_W'(DEB_CYC - 1)) begin
            stable_d = sync2_q[g]; // R23
          end else begin
            cnt_d = cnt_q + DEB_W'(1);
          end
        end
      end
      always_ff @(posedge i_ref_clk or posedge i_reset) begin
        if (i_reset) begin
          cnt_q <= '0;
          stable_q <= 1'b0;
        end else begin
          cnt_q <= cnt_d;
          stable_q <= stable_d;
        end
      end
      assign held[g] = stable_q;
    end
  endgenerate

  // press episodes: at most one event fires, when every button is released
  logic [2:0] seen_q, seen_d;
  logic pair_up_q, pair_up_d, pair_dn_q, pair_dn_d;
  btn_evt_type evt_q, evt_d;
  always_comb begin
    seen_d = seen_q | held;
    pair_up_d = pair_up_q | (held[0] & held[1]);
    pair_dn_d = pair_dn_q | (held[0] & held[2]);
    evt_d = '0;
    if (held == 3'h0 && seen_q != 3'h0) begin
      seen_d = 3'h0;
      pair_up_d = 1'b0;
      pair_dn_d = 1'b0;
      if (pair_up_q && !pair_dn_q) begin
        evt_d.prog_up = 1'b1; // R8
      end else if (pair_dn_q && !pair_up_q) begin
        evt_d.prog_down = 1'b1; // R8
      end else if (!pair_up_q && !pair_dn_q) begin
        // mixed presses that never overlapped as a pair are dropped
        evt_d.prog = (seen_q == 3'h1); // R7
        evt_d.up = (seen_q == 3'h2); // R7
        evt_d.down = (seen_q == 3'h4); // R7
      end
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      seen_q <= 3'h0;
      pair_up_q <= 1'b0;
      pair_dn_q <= 1'b0;
      evt_q <= '0;
    end else begin
      seen_q <= seen_d;
      pair_up_q <= pair_up_d;
      pair_dn_q <= pair_dn_d;
      evt_q <= evt_d;
    end
  end

  function automatic logic signed [15:0] clamp(
    input logic signed [15:0] v,
    input logic signed [15:0] lo,
    input logic signed [15:0] hi
  );
    if (v < lo) return lo;
    if (v > hi) return hi;
    return v;
  endfunction

  // menu sequencer and stored settings
  menu_state_type state_q, state_d;
  logic [LAMP_W-1:0] lamp_q, lamp_d;
  logic [FLASH_W-1:0] flash_q, flash_d;
  logic phase_q, phase_d;
  logic out_sel_q, out_sel_d;
  logic volt_q, volt_d;
  logic signed [15:0] edit_q, edit_d;
  logic signed [15:0] offset_q, offset_d, scale_q, scale_d;
  logic signed [15:0] tlo_q, tlo_d, thi_q, thi_d, span_q, span_d;
  logic [1:0] radix_q, radix_d;
  logic signed [15:0] lim_lo, lim_hi, lo_min, lo_max, hi_min, hi_max;

  always_comb begin
    lo_min = volt_q ? VLT_LO_MIN : CUR_LO_MIN; // R17
    lo_max = volt_q ? VLT_LO_MAX : CUR_LO_MAX; // R17
    hi_min = volt_q ? VLT_HI_MIN : CUR_HI_MIN; // R18
    hi_max = volt_q ? VLT_HI_MAX : CUR_HI_MAX; // R18
    case (state_q)
      ST_RADIX: begin
        lim_lo = RADIX_MIN;
        lim_hi = RADIX_MAX;
      end
      ST_OLOW: begin
        lim_lo = lo_min;
        lim_hi = lo_max;
      end
      ST_OHIGH: begin
        lim_lo = hi_min;
        lim_hi = hi_max;
      end
      default: begin
        lim_lo = SET_MIN; // R2 R4
        lim_hi = SET_MAX; // R2 R4
      end
    endcase
  end

  always_comb begin
    state_d = state_q;
    lamp_d = lamp_q;
    flash_d = flash_q + FLASH_W'(1);
    phase_d = phase_q;
    out_sel_d = out_sel_q;
    edit_d = edit_q;
    offset_d = offset_q;
    scale_d = scale_q;
    tlo_d = tlo_q;
    thi_d = thi_q;
    span_d = span_q;
    radix_d = radix_q;
    if (flash_q == FLASH_W'(FLASH_CYC - 1)) begin
      flash_d = '0;
      phase_d = !phase_q; // R9
    end
    if (evt_q.up && edit_q < lim_hi) begin
      edit_d = edit_q + 16'sh0001; // R10
    end
    if (evt_q.down && edit_q > lim_lo) begin
      edit_d = edit_q - 16'sh0001; // R10
    end
    case (state_q)
      ST_LAMP: begin
        lamp_d = lamp_q + LAMP_W'(1);
        if (lamp_q == LAMP_W'(LAMP_CYC - 1)) begin
          state_d = ST_RUN; // R1
        end
      end
      ST_RUN: begin
        if (evt_q.prog_up || evt_q.prog_down) begin
          state_d = ST_CAL_OFF; // R22
        end
      end
      ST_CAL_OFF: begin
        if (evt_q.up || evt_q.down) begin
          state_d = ST_CAL_ON; // R12
        end else if (evt_q.prog) begin
          state_d = ST_RUN;
        end
      end
      ST_CAL_ON: begin
        if (evt_q.up || evt_q.down) begin
          state_d = ST_CAL_OFF;
        end else if (evt_q.prog) begin
          if (aout_ok) begin
            state_d = ST_SEL; // R12
            out_sel_d = 1'b1;
          end else begin
            state_d = ST_ZERO_SHIFT_PARAMETER; // R11 R13
            edit_d = offset_q; // R14
          end
        end
      end
      ST_SEL: begin
        if (evt_q.up || evt_q.down) begin
          out_sel_d = !out_sel_q; // R12
        end else if (evt_q.prog) begin
          if (!out_sel_q) begin
            state_d = ST_ZERO_SHIFT_PARAMETER; // R14
            edit_d = offset_q; // R14
          end else if (aout_ok) begin
            state_d = ST_OLOW; // R17
            edit_d = clamp(tlo_q, lo_min, lo_max);
          end else begin
            state_d = ST_SPAN; // R11 R20
            edit_d = span_q; // R20
          end
        end
      end
      ST_ZERO_SHIFT_PARAMETER: begin
        if (evt_q.prog) begin
          offset_d = edit_q; // R16
          state_d = ST_GAIN_PARAMETER; // R14
          edit_d = scale_q; // R14 R24
        end
      end
      ST_GAIN_PARAMETER: begin
        if (evt_q.prog) begin
          scale_d = edit_q; // R16
          state_d = ST_RADIX; // R15
          edit_d = {14'h0000, radix_q}; // R15
        end
      end
      ST_RADIX: begin
        if (evt_q.prog) begin
          radix_d = edit_q[1:0]; // R16
          state_d = ST_RUN;
        end
      end
      ST_OLOW: begin
        if (evt_q.prog) begin
          tlo_d = edit_q; // R16
          state_d = ST_OHIGH; // R19
          edit_d = clamp(thi_q, hi_min, hi_max); // R19
        end
      end
      ST_OHIGH: begin
        if (evt_q.prog) begin
          thi_d = edit_q; // R16
          state_d = ST_RUN; // R18
        end
      end
      ST_SPAN: begin
        if (evt_q.prog) begin
          span_d = edit_q; // R16
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
    // restart the flash so each step opens with its code name
    if (state_d != state_q) begin
      flash_d = '0;
      phase_d = 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      state_q <= ST_LAMP;
      lamp_q <= '0;
      flash_q <= '0;
      phase_q <= 1'b0;
      out_sel_q <= 1'b1;
      edit_q <= OFFSET_RST;
      offset_q <= OFFSET_RST; // R2 R24
      scale_q <= SCALE_RST; // R4 R24
      tlo_q <= TRIM_LO_RST;
      thi_q <= TRIM_HI_RST;
      span_q <= SPAN_RST;
      radix_q <= RADIX_RST;
    end else begin
      state_q <= state_d;
      lamp_q <= lamp_d;
      flash_q <= flash_d;
      phase_q <= phase_d;
      out_sel_q <= out_sel_d;
      edit_q <= edit_d;
      offset_q <= offset_d;
      scale_q <= scale_d;
      tlo_q <= tlo_d;
      thi_q <= thi_d;
      span_q <= span_d;
      radix_q <= radix_d;
    end
  end

  // rescaling: reading = scale * mv / 2000 + offset
  logic signed [31:0] prod, sum;
  logic signed [15:0] reading_q, reading_d;
  logic [1:0] over_q, over_d;
  always_comb begin
    prod = 32'(scale_q) * 32'(i_conv_mv); // R5
    sum = prod / REF_MV + 32'(offset_q); // R3 R5
    reading_d = reading_q;
    over_d = over_q;
    if (i_conv_valid) begin
      reading_d = sum[15:0];
      over_d = OVER_NONE;
      if (i_conv_mv > IN_MAX_MV || sum > 32'(SET_MAX)) begin
        over_d = OVER_POS; // R6
      end else if (i_conv_mv < IN_MIN_MV || sum < 32'(SET_MIN)) begin
        over_d = OVER_NEG; // R6
      end
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      reading_q <= OFFSET_RST;
      over_q <= OVER_NONE;
    end else begin
      reading_q <= reading_d;
      over_q <= over_d;
    end
  end

  // display and analog outputs, all registered
  disp_type disp_d, disp_q;
  label_type name;
  logic signed [15:0] tlo_out_q, thi_out_q, tlo_out_d, thi_out_d;
  always_comb begin
    disp_d.kind = DK_NUM;
    disp_d.label = LB_NONE;
    disp_d.value = edit_q;
    disp_d.radix = radix_q;
    case (state_q)
      ST_ZERO_SHIFT_PARAMETER: name = LB_ZERO_SHIFT;
      ST_GAIN_PARAMETER: name = LB_GAIN;
      ST_RADIX: name = LB_RADIX;
      ST_OLOW: name = LB_LOW_TRIM;
      ST_OHIGH: name = LB_HIGH_TRIM;
      ST_SPAN: name = LB_SPAN;
      default: name = LB_CAL;
    endcase
    case (state_q)
      ST_LAMP: disp_d.kind = DK_LAMP; // R1
      ST_RUN: begin
        disp_d.value = reading_q;
        if (over_q == OVER_POS) begin
          disp_d.kind = phase_q ? DK_BLANK : DK_OVER_TOP; // R21
        end else if (over_q == OVER_NEG) begin
          disp_d.kind = phase_q ? DK_BLANK : DK_OVER_BOT; // R21
        end
      end
      ST_CAL_OFF, ST_CAL_ON, ST_SEL: begin
        disp_d.kind = DK_LABEL;
        disp_d.label = LB_CAL; // R12
        if (phase_q) begin
          if (state_q == ST_CAL_OFF) begin
            disp_d.label = LB_OFF;
          end else if (state_q == ST_CAL_ON) begin
            disp_d.label = LB_ON;
          end else begin
            disp_d.label = out_sel_q ? LB_OUT : LB_INPUT;
          end
        end
      end
      default: begin
        if (!phase_q) begin
          disp_d.kind = DK_LABEL; // R9
          disp_d.label = name; // R9
        end
      end
    endcase
    // the output follows the trim live so it can be set on a meter
    tlo_out_d = (state_q == ST_OLOW) ? edit_q : tlo_q;
    thi_out_d = (state_q == ST_OHIGH) ? edit_q : thi_q;
  end
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      disp_q <= '0;
      tlo_out_q <= TRIM_LO_RST;
      thi_out_q <= TRIM_HI_RST;
    end else begin
      disp_q <= disp_d;
      tlo_out_q <= tlo_out_d;
      thi_out_q <= thi_out_d;
    end
  end

  // avalon slave: one wait cycle, then the answer
  logic wait_q, wait_d;
  logic [31:0] rdata_q, rdata_d;
  logic req;
  always_comb begin
    req = i_avs_read | i_avs_write;
    wait_d = !(req && wait_q);
    rdata_d = rdata_q;
    volt_d = volt_q;
    if (i_avs_read && wait_q) begin
      rdata_d = 32'h0000_0000;
      case (i_avs_address)
        REG_CTRL: rdata_d[CTRL_VOLT_BIT] = volt_q;
        REG_STATUS: begin
          rdata_d[ST_STATE_LSB +: 4] = state_q;
          rdata_d[ST_OVER_LSB +: 2] = over_q;
          rdata_d[ST_AOUT_BIT] = aout_ok;
        end
        REG_OFFSET: rdata_d = 32'(offset_q);
        REG_SCALE: rdata_d = 32'(scale_q);
        REG_TRIM: rdata_d = {thi_q, tlo_q};
        REG_READING: rdata_d = 32'(reading_q);
        REG_SPAN: rdata_d = 32'(span_q);
        default: rdata_d = 32'h0000_0000;
      endcase
    end
    if (i_avs_write && !wait_q && i_avs_address == REG_CTRL &&
        i_avs_byteenable[0]) begin
      volt_d = i_avs_writedata[CTRL_VOLT_BIT];
    end
  end
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      wait_q <= 1'b1;
      rdata_q <= 32'h0000_0000;
      volt_q <= 1'b0;
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      volt_q <= volt_d;
    end
  end

  assign o_avs_readdata = rdata_q;
  assign o_avs_waitrequest = wait_q;
  assign o_disp = disp_q;
  assign o_trim_low = tlo_out_q;
  assign o_trim_high = thi_out_q;
  assign o_span = span_q;
  assign o_aout_volt_mode = volt_q;
endmodule
`default_nettype wire

// ===== verif/meter_menu_props.sv
`timescale 1ns/1ps
`default_nettype none
module meter_menu_props
  import meter_pkg::*;
#(
  parameter int LAMP_CYC = 64
) (
  input wire logic i_ref_clk,
  input wire logic i_reset,
  input wire logic i_btn_up,
  input wire logic i_btn_down,
  input wire logic [2:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  input wire logic [3:0] i_avs_byteenable,
  input wire logic o_avs_waitrequest,
  input wire disp_type o_disp,
  input wire logic signed [15:0] o_trim_low,
  input wire logic signed [15:0] o_trim_high,
  input wire logic o_aout_volt_mode
);
  int age_q;
  int age_d;
  logic req;
  logic ctrl_wr;
  logic wd0;
  assign req = i_avs_read || i_avs_write;
  assign wd0 = i_avs_writedata[0];
  assign ctrl_wr = i_avs_write && !o_avs_waitrequest &&
    i_avs_address == REG_CTRL && i_avs_byteenable[0];
  // saturates so the lamp window is judged once per reset
  always_comb begin
    age_d = (age_q < LAMP_CYC + 8) ? age_q + 1 : age_q;
  end
  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      age_q <= 0;
    end else begin
      age_q <= age_d;
    end
  end
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  lamp_hold_a:
    assert property (age_q < LAMP_CYC - 2 |-> o_disp.kind == DK_LAMP)
    else $error("lamp test cut short");
  lamp_end_a:
    assert property (age_q > LAMP_CYC + 4 |-> o_disp.kind != DK_LAMP)
    else $error("lamp test never ended");
  ack_once_a:
    assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
    else $error("bus answer longer than one cycle");
  ack_cause_a:
    assert property ($fell(o_avs_waitrequest) |-> $past(req))
    else $error("bus answer without request");
  ack_due_a:
    assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("bus request not answered");
  mode_write_a:
    assert property (ctrl_wr |=> o_aout_volt_mode == $past(wd0))
    else $error("output mode write lost");
  low_trim_a:
    assert property (o_trim_low >= VLT_LO_MIN && o_trim_low <= CUR_LO_MAX)
    else $error("low trim out of range");
  high_trim_a:
    assert property (o_trim_high >= VLT_HI_MIN && o_trim_high <= CUR_HI_MAX)
    else $error("high trim out of range");
  num_range_a:
    assert property (o_disp.kind == DK_NUM |-> $signed(o_disp.value)
      >= SET_MIN && $signed(o_disp.value) <= SET_MAX)
    else $error("shown number beyond display range");
  trim_release_a:
    assert property ($changed(o_trim_low) |-> !i_btn_up && !i_btn_down)
    else $error("trim moved while a key was held");
endmodule
bind meter_menu meter_menu_props #(.LAMP_CYC(LAMP_CYC)) u_meter_menu_props (
  .i_ref_clk, .i_reset, .i_btn_up, .i_btn_down, .i_avs_address,
  .i_avs_read, .i_avs_write, .i_avs_writedata, .i_avs_byteenable,
  .o_avs_waitrequest, .o_disp, .o_trim_low, .o_trim_high,
  .o_aout_volt_mode
);
`default_nettype wire

// ===== verif/meter_operator.sv
`timescale 1ns/1ps
`default_nettype none
module meter_operator (
  input wire logic i_ref_clk,
  output logic o_btn_program,
  output logic o_btn_up,
  output logic o_btn_down
);
  logic [2:0] held;
  assign {o_btn_program, o_btn_up, o_btn_down} = held;
  initial held = 3'h0;
  // contacts chatter once on make, shorter than the debounce window
  task automatic press(input logic [2:0] keys);
    @(posedge i_ref_clk);
    held <= keys;
    @(posedge i_ref_clk);
    held <= 3'h0;
    @(posedge i_ref_clk);
    held <= keys;
    repeat (12) @(posedge i_ref_clk);
    held <= 3'h0;
    // a person waits for the display to react before pressing again
    repeat (16) @(posedge i_ref_clk);
  endtask
endmodule
`default_nettype wire

// ===== verif/meter_menu_test.sv
`timescale 1ns/1ps
`default_nettype none
`define check(got, exp) begin \
  tests_run++; \
  if ((got) !== (exp)) begin \
    fails++; \
    $display("unexpected at %0t: got %0h want %0h", $time, got, exp); \
  end \
end
module meter_menu_test
  import meter_pkg::*;
;
  localparam int LAMP = 64;
  localparam int FLASH = 8;
  logic clk, rst, aout, cv, rd, wr, wt, volt, p, u, d;
  logic signed [15:0] mv, tlo, thi, spn;
  logic [2:0] addr;
  logic [31:0] wd, rdata;
  logic [3:0] be;
  disp_type disp;
  int fails = 0;
  int tests_run = 0;
  meter_menu #(.LAMP_CYC(LAMP), .FLASH_CYC(FLASH), .DEB_CYC(4)) u_meter_menu (
    .i_ref_clk(clk), .i_reset(rst), .i_btn_program(p), .i_btn_up(u),
    .i_btn_down(d), .i_aout_present(aout), .i_conv_valid(cv),
    .i_conv_mv(mv), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be),
    .o_avs_readdata(rdata), .o_avs_waitrequest(wt), .o_disp(disp),
    .o_trim_low(tlo), .o_trim_high(thi), .o_span(spn),
    .o_aout_volt_mode(volt)
  );
  meter_operator u_meter_operator (
    .i_ref_clk(clk), .o_btn_program(p), .o_btn_up(u), .o_btn_down(d)
  );
  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic bus(input logic w, input logic [2:0] a,
      input logic [31:0] v, output logic [31:0] q);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wd <= v;
    // no cycle limit here: a slave that never answers is left to the watchdog
    do begin
      @(posedge clk);
    end while (wt !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic expect_reg(input logic [2:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    `check(q, e)
  endtask
  task automatic state_is(input menu_state_type s);
    logic [31:0] q;
    bus(1'b0, REG_STATUS, 32'h0, q);
    `check(q[3:0], s)
  endtask
  task automatic key(input logic [2:0] k);
    u_meter_operator.press(k);
  endtask
  task automatic conv(input logic signed [15:0] v);
    @(posedge clk);
    cv <= 1'b1;
    mv <= v;
    @(posedge clk);
    cv <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // the edit display must show both the code and the value in turn
  task automatic shows(input label_type lb, input logic signed [15:0] v);
    logic sl, sv;
    sl = 0;
    sv = 0;
    repeat (3 * FLASH + 4) begin
      @(posedge clk);
      if (disp.kind === DK_LABEL && disp.label === lb) sl = 1;
      if (disp.kind === DK_NUM && disp.value === v) sv = 1;
    end
    `check({sl, sv}, 2'b11)
  endtask
  task automatic flashes(input disp_kind_type k);
    logic sk, sn;
    sk = 0;
    sn = 0;
    repeat (2 * FLASH + 2) begin
      @(posedge clk);
      if (disp.kind === k) sk = 1;
      if (disp.kind === DK_NUM) sn = 1;
    end
    `check({sk, sn}, 2'b10)
  endtask
  task automatic t_power;
    logic [2:0] a[5] = '{REG_OFFSET, REG_SCALE, REG_TRIM, REG_SPAN, 3'h7};
    logic [31:0] e[5] = '{32'(OFFSET_RST), 32'(SCALE_RST),
      {TRIM_HI_RST, TRIM_LO_RST}, 32'(SPAN_RST), 32'h0};
    logic [31:0] q;
    `check(disp.kind, DK_LAMP)
    repeat (LAMP + 4) @(posedge clk);
    `check(disp.kind === DK_LAMP, 1'b0)
    state_is(ST_RUN);
    bus(1'b1, 3'h7, 32'hFFFFFFFF, q);
    bus(1'b1, REG_OFFSET, 32'h00000005, q);
    foreach (a[i]) expect_reg(a[i], e[i]);
    bus(1'b1, REG_CTRL, 32'h1, q);
    expect_reg(REG_CTRL, 32'h1);
    `check(volt, 1'b1)
    bus(1'b1, REG_CTRL, 32'h0, q);
  endtask
  task automatic t_scale;
    logic signed [15:0] m[5] = '{16'sh0000, 16'sh07D0, 16'shFC18,
      16'sh07D1, 16'shFC17};
    logic [1:0] o[5] = '{OVER_NONE, OVER_NONE, OVER_NONE, OVER_POS,
      OVER_NEG};
    logic [31:0] q;
    foreach (m[i]) begin
      conv(m[i]);
      bus(1'b0, REG_STATUS, 32'h0, q);
      `check(q[5:4], o[i])
      if (o[i] === OVER_POS) flashes(DK_OVER_TOP);
      else if (o[i] === OVER_NEG) flashes(DK_OVER_BOT);
      else expect_reg(REG_READING, 32'(m[i]));
    end
  endtask
  task automatic t_input;
    key(3'h6);
    state_is(ST_CAL_OFF);
    key(3'h3);
    state_is(ST_CAL_OFF);
    key(3'h2);
    state_is(ST_CAL_ON);
    key(3'h4);
    state_is(ST_ZERO_SHIFT_PARAMETER);
    shows(LB_ZERO_SHIFT, OFFSET_RST);
    repeat (3) key(3'h2);
    key(3'h1);
    shows(LB_ZERO_SHIFT, 16'sh0002);
    expect_reg(REG_OFFSET, 32'(OFFSET_RST));
    key(3'h4);
    expect_reg(REG_OFFSET, 32'h2);
    shows(LB_GAIN, SCALE_RST);
    key(3'h1);
    key(3'h4);
    state_is(ST_RADIX);
    shows(LB_RADIX, 16'(RADIX_RST));
    key(3'h4);
    state_is(ST_RUN);
    conv(16'sh07D0);
    expect_reg(REG_READING, 32'(SCALE_RST - 1 + 2));
  endtask
  task automatic t_output;
    @(posedge clk);
    aout <= 1'b1;
    key(3'h5);
    state_is(ST_CAL_OFF);
    key(3'h1);
    key(3'h4);
    state_is(ST_SEL);
    key(3'h4);
    state_is(ST_OLOW);
    key(3'h1);
    `check(tlo, TRIM_LO_RST - 16'sh0001)
    key(3'h4);
    state_is(ST_OHIGH);
    shows(LB_HIGH_TRIM, CUR_HI_MIN);
    key(3'h2);
    `check(thi, CUR_HI_MIN + 16'sh0001)
    key(3'h4);
    state_is(ST_RUN);
    expect_reg(REG_TRIM, {CUR_HI_MIN + 16'sh1, TRIM_LO_RST - 16'sh1});
  endtask
  // voltage mode: the stored high trim is pulled into the narrower range
  task automatic t_volt;
    logic [31:0] q;
    bus(1'b1, REG_CTRL, 32'h1, q);
    key(3'h6);
    key(3'h2);
    key(3'h4);
    key(3'h4);
    key(3'h4);
    state_is(ST_OHIGH);
    shows(LB_HIGH_TRIM, VLT_HI_MAX);
    key(3'h2);
    `check(thi, VLT_HI_MAX)
    key(3'h4);
    state_is(ST_RUN);
    bus(1'b1, REG_CTRL, 32'h0, q);
  endtask
  task automatic t_span;
    key(3'h6);
    key(3'h2);
    key(3'h4);
    state_is(ST_SEL);
    @(posedge clk);
    aout <= 1'b0;
    key(3'h4);
    state_is(ST_SPAN);
    shows(LB_SPAN, SPAN_RST);
    key(3'h1);
    `check(spn, SPAN_RST)
    key(3'h4);
    state_is(ST_RUN);
    `check(spn, SPAN_RST - 16'sh0001)
  endtask
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  initial begin
    rst = 1'b1;
    aout = 1'b0;
    cv = 1'b0;
    mv = 16'sh0000;
    addr = 3'h0;
    rd = 1'b0;
    wr = 1'b0;
    wd = 32'h0;
    be = 4'hF;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_power;
    t_scale;
    t_input;
    t_output;
    t_volt;
    t_span;
    wrap_up;
  end
  // whole run needs about 1500 cycles; this bound only catches hangs
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    wrap_up;
  end
endmodule
`default_nettype wire
